// File: hw/ppom_pkg.sv
// constants and types shared by the port pin override mux
package ppom_pkg;
    // ==========================================================
    // port geometry and register bus
    localparam int PPOM_PINS = 8;
    localparam int PPOM_AW = 3;
    localparam logic [PPOM_AW-1:0] PPOM_OFS_DIR = 3'h0;
    localparam logic [PPOM_AW-1:0] PPOM_OFS_OUT = 3'h1;
    localparam logic [PPOM_AW-1:0] PPOM_OFS_IN = 3'h2;
    localparam logic [PPOM_AW-1:0] PPOM_OFS_CTRL = 3'h3;
    // ==========================================================
    // control register fields and register reset values
    localparam int PPOM_CTRL_PUD_BIT = 0;
    localparam int PPOM_CTRL_REF_BIT = 1;
    localparam logic [7:0] PPOM_DIR_RST = 8'h00;
    localparam logic [7:0] PPOM_OUT_RST = 8'h00;
    localparam logic [1:0] PPOM_CTRL_RST = 2'h0;
    // ==========================================================
    // fixed pin roles on this port
    localparam int PPOM_PIN_REF = 0;
    localparam int PPOM_PIN_T0CNT = 3;
    localparam int PPOM_PIN_SCLK = 4;
    localparam int PPOM_PIN_SDO = 5;
    localparam int PPOM_PIN_SDI = 6;
    localparam int PPOM_PIN_CAP = 7;
    // ==========================================================
    // controller sleep states
    typedef enum logic [2:0] {
        PPOM_ACTIVE = 3'h0,
        PPOM_IDLE = 3'h1,
        PPOM_POWERDOWN = 3'h3,
        PPOM_POWERSAVE = 3'h2,
        PPOM_STANDBY = 3'h6
    } ppom_sleep_t;
endpackage

// File: hw/ppom_sync.sv
// two-stage synchroniser for a vector of independent levels
module ppom_sync import ppom_pkg::*; #(
    parameter int WIDTH = PPOM_PINS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_r;
    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_r <= '0;
            sync_out <= '0;
        end else begin
            stage1_r <= async_in;
            sync_out <= stage1_r;
        end
    end
endmodule // ppom_sync

// File: hw/ppom_pin_cell.sv
// combinational override merge for one port pin
module ppom_pin_cell import ppom_pkg::*; (
    input wire logic pinDirectionBit,
    input wire logic pinOutputBit,
    input wire logic globalPullupDisable,
    input wire logic sleepClamp,
    input wire logic pullupOvrEn,
    input wire logic pullupOvrVal,
    input wire logic dirOvrEn,
    input wire logic dirOvrVal,
    input wire logic outvalOvrEn,
    input wire logic outvalOvrVal,
    input wire logic inenOvrEn,
    input wire logic inenOvrVal,
    input wire logic padIn,
    output logic pullupOn,
    output logic driveEn,
    output logic driveVal,
    output logic digIn
);
    // ==========================================================
    // pull-up, driver and value selection, no storage so it acts in-cycle
    wire logic plainPullup = ~pinDirectionBit & pinOutputBit & ~globalPullupDisable;
    wire logic inEnable = inenOvrEn ? inenOvrVal : ~sleepClamp;
    assign pullupOn = pullupOvrEn ? pullupOvrVal : plainPullup;
    assign driveEn = dirOvrEn ? dirOvrVal : pinDirectionBit;
    assign driveVal = outvalOvrEn ? outvalOvrVal : pinOutputBit;
    // disabled input is clamped low ahead of the trigger, avoiding float current
    assign digIn = padIn & inEnable;
endmodule // ppom_pin_cell

// File: hw/ppom_port.sv
// port A pin logic: registers, per-pin override merge and peripheral routing
//
// Local design decisions: the strobed register port and the placing of the registers.
module ppom_port import ppom_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic [PPOM_AW-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic [2:0] sleepState,
    input wire logic [7:0] pullupOvrEn,
    input wire logic [7:0] pullupOvrVal,
    input wire logic [7:0] dirOvrEn,
    input wire logic [7:0] dirOvrVal,
    input wire logic [7:0] outvalOvrEn,
    input wire logic [7:0] outvalOvrVal,
    input wire logic [7:0] toggleOvrEn,
    input wire logic [7:0] inenOvrEn,
    input wire logic [7:0] inenOvrVal,
    input wire logic serialDataOutEn,
    input wire logic serialDataOut,
    input wire logic timer1MatchAOutEn,
    input wire logic timer1MatchAOut,
    input wire logic timer1MatchBOutEn,
    input wire logic timer1MatchBOut,
    input wire logic timer0MatchBOutEn,
    input wire logic timer0MatchBOut,
    input wire logic [7:0] padIn,
    output logic [7:0] padOut,
    output logic [7:0] padOe,
    output logic [7:0] padPullup,
    output logic [7:0] pinRawIn,
    output logic [7:0] pinChangeSrc,
    output logic timer0CountIn,
    output logic timer1CountIn,
    output logic serialIfClock,
    output logic serialDataIn,
    output logic timer1CaptureIn
);
    // ==========================================================
    // register state
    logic [7:0] dirReg_r;
    logic [7:0] dirReg_nxt;
    logic [7:0] outReg_r;
    logic [7:0] outReg_nxt;
    logic [1:0] ctrlReg_r;
    logic [1:0] ctrlReg_nxt;
    logic [7:0] rdata_nxt;
    logic [7:0] pinInSync;
    logic [7:0] periphSync;
    logic [7:0] cellPullup;
    logic [7:0] cellDriveEn;
    logic [7:0] cellDriveVal;
    logic [7:0] digIn;

    // one set of strobes serves the whole port; decode is shared by all pins
    wire logic wrDir = regWrite && (regAddr == PPOM_OFS_DIR);
    wire logic wrOut = regWrite && (regAddr == PPOM_OFS_OUT);
    wire logic wrIn = regWrite && (regAddr == PPOM_OFS_IN);
    wire logic wrCtrl = regWrite && (regAddr == PPOM_OFS_CTRL);
    wire logic globalPullupDisable = ctrlReg_r[PPOM_CTRL_PUD_BIT];
    wire logic adcRefSelectBit = ctrlReg_r[PPOM_CTRL_REF_BIT];

    // deep sleep states clamp, idle and active leave inputs live
    wire logic sleepClamp = (sleepState == PPOM_POWERDOWN) || (sleepState == PPOM_POWERSAVE)
        || (sleepState == PPOM_STANDBY);

    // ==========================================================
    // next-state decode
    assign dirReg_nxt = wrDir ? regWdata : dirReg_r;
    // a write lands first, then input-register writes and toggle overrides flip it
    assign outReg_nxt = (wrOut ? regWdata : outReg_r) ^ (wrIn ? regWdata : 8'h00) ^ toggleOvrEn;
    assign ctrlReg_nxt = wrCtrl ? regWdata[1:0] : ctrlReg_r;
    // unmapped offsets read as zero
    assign rdata_nxt = !regRead ? 8'h00 :
        (regAddr == PPOM_OFS_DIR) ? dirReg_r :
        (regAddr == PPOM_OFS_OUT) ? outReg_r :
        (regAddr == PPOM_OFS_IN) ? pinInSync :
        (regAddr == PPOM_OFS_CTRL) ? {6'h00, ctrlReg_r} : 8'h00;

    // registers and read data, read answer valid only the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            dirReg_r <= PPOM_DIR_RST;
            outReg_r <= PPOM_OUT_RST;
            ctrlReg_r <= PPOM_CTRL_RST;
            regRdata <= 8'h00;
        end else begin
            dirReg_r <= dirReg_nxt;
            outReg_r <= outReg_nxt;
            ctrlReg_r <= ctrlReg_nxt;
            regRdata <= rdata_nxt;
        end
    end

    // ==========================================================
    // built-in peripheral requests joined with the generic override ports
    wire logic [7:0] fixedOvEn = {timer0MatchBOutEn, timer1MatchAOutEn,
        serialDataOutEn | timer1MatchBOutEn, 5'h00};
    wire logic [7:0] fixedOvVal = {timer0MatchBOut, timer1MatchAOut,
        serialDataOutEn ? serialDataOut : timer1MatchBOut, 5'h00};
    wire logic [7:0] effOvEn = outvalOvrEn | fixedOvEn;
    wire logic [7:0] effOvVal = (fixedOvEn & fixedOvVal) | (~fixedOvEn & outvalOvrVal);

    // one merge cell per pin; no flop sits between override and pad
    genvar gi;
    generate
        for (gi = 0; gi < PPOM_PINS; gi++) begin : g_pin
            ppom_pin_cell u_cell (
                .pinDirectionBit(dirReg_r[gi]),
                .pinOutputBit(outReg_r[gi]),
                .globalPullupDisable(globalPullupDisable),
                .sleepClamp(sleepClamp),
                .pullupOvrEn(pullupOvrEn[gi]),
                .pullupOvrVal(pullupOvrVal[gi]),
                .dirOvrEn(dirOvrEn[gi]),
                .dirOvrVal(dirOvrVal[gi]),
                .outvalOvrEn(effOvEn[gi]),
                .outvalOvrVal(effOvVal[gi]),
                .inenOvrEn(inenOvrEn[gi]),
                .inenOvrVal(inenOvrVal[gi]),
                .padIn(padIn[gi]),
                .pullupOn(cellPullup[gi]),
                .driveEn(cellDriveEn[gi]),
                .driveVal(cellDriveVal[gi]),
                .digIn(digIn[gi])
            );
        end
    endgenerate

    // ==========================================================
    // pad side; reference pin gives way to the analog reference
    wire logic [7:0] refMask = adcRefSelectBit ? 8'h01 << PPOM_PIN_REF : 8'h00;
    assign padPullup = cellPullup & ~refMask;
    assign padOe = cellDriveEn & ~refMask;
    assign padOut = cellDriveVal;

    // ==========================================================
    // input paths: raw trigger output out, own copies synchronised
    ppom_sync #(.WIDTH(PPOM_PINS)) u_read_sync (
        .clk(clk),
        .rst(rst),
        .async_in(digIn),
        .sync_out(pinInSync)
    );
    ppom_sync #(.WIDTH(PPOM_PINS)) u_periph_sync (
        .clk(clk),
        .rst(rst),
        .async_in(digIn),
        .sync_out(periphSync)
    );
    assign pinRawIn = digIn;
    assign pinChangeSrc = periphSync;
    // count and serial clock inputs are clocks, so they stay raw
    assign timer0CountIn = digIn[PPOM_PIN_T0CNT];
    assign timer1CountIn = digIn[PPOM_PIN_SCLK];
    assign serialIfClock = digIn[PPOM_PIN_SCLK];
    assign serialDataIn = periphSync[PPOM_PIN_SDI];
    assign timer1CaptureIn = periphSync[PPOM_PIN_CAP];

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    generate
        for (gi = 0; gi < PPOM_PINS; gi++) begin : g_chk
            a_pullup_plain: assert property (!pullupOvrEn[gi] && !refMask[gi] |->
                padPullup[gi] == (!dirReg_r[gi] && outReg_r[gi] && !globalPullupDisable))
                else $error("pull-up wrong without override");
            a_pullup_ovr: assert property (pullupOvrEn[gi] && !refMask[gi] |->
                padPullup[gi] == pullupOvrVal[gi])
                else $error("pull-up ignores override value");
            a_drive_plain: assert property (!dirOvrEn[gi] && !refMask[gi] |-> padOe[gi] == dirReg_r[gi])
                else $error("driver not following direction bit");
            a_drive_ovr: assert property (dirOvrEn[gi] && !refMask[gi] |-> padOe[gi] == dirOvrVal[gi])
                else $error("driver ignores direction override");
            // expected level comes from the request ports, not from the merged override
            a_outval_sel: assert property (padOe[gi] && outvalOvrEn[gi] && !fixedOvEn[gi] |->
                padOut[gi] == outvalOvrVal[gi])
                else $error("driven level ignores value override");
            a_outval_plain: assert property (padOe[gi] && !outvalOvrEn[gi] && !fixedOvEn[gi] |->
                padOut[gi] == outReg_r[gi])
                else $error("driven level not from output bit");
            a_clamp_sleep: assert property (!inenOvrEn[gi] && sleepClamp |-> !pinRawIn[gi])
                else $error("input not clamped in deep sleep");
            a_inen_ovr: assert property (inenOvrEn[gi] && inenOvrVal[gi] |-> pinRawIn[gi] == padIn[gi])
                else $error("input enable override ignored");
            a_toggle_flip: assert property (!wrOut && (toggleOvrEn[gi] ^ (wrIn && regWdata[gi])) |=>
                outReg_r[gi] != $past(outReg_r[gi]))
                else $error("output bit not toggled");
            a_read_sync: assert property (pinInSync[gi] == $past(pinRawIn[gi], 2) || $past(rst, 2))
                else $error("port read not two cycles behind raw input");
            // pin-change sources see the same two-flop delay as the port read
            a_pcint_route: assert property (pinChangeSrc[gi] == $past(pinRawIn[gi], 2) || $past(rst, 2))
                else $error("pin-change source not following its pin");
        end
    endgenerate

    a_ref_pin_off: assert property (adcRefSelectBit |-> !padOe[PPOM_PIN_REF] && !padPullup[PPOM_PIN_REF])
        else $error("reference pin still driven or pulled");
    a_pud_global: assert property (globalPullupDisable && (pullupOvrEn == 8'h00) |-> padPullup == 8'h00)
        else $error("pull-up alive under global disable");
    a_read_dir: assert property (regRead && regAddr == PPOM_OFS_DIR |=> regRdata == $past(dirReg_r))
        else $error("direction readback wrong");

    c_toggle_write: cover property (wrIn && regWdata != 8'h00);
    c_serial_out: cover property (serialDataOutEn && padOe[PPOM_PIN_SDO]);
    // fixed peripheral outputs reach their own pins only
    a_sdo_value: assert property (serialDataOutEn && padOe[PPOM_PIN_SDO] |->
        padOut[PPOM_PIN_SDO] == serialDataOut)
        else $error("serial data not on its pin");
    a_match_a_pin: assert property (timer1MatchAOutEn && padOe[PPOM_PIN_SDI] |->
        padOut[PPOM_PIN_SDI] == timer1MatchAOut)
        else $error("timer 1 match A not on its pin");
    a_match_b_pin: assert property (timer0MatchBOutEn && padOe[PPOM_PIN_CAP] |->
        padOut[PPOM_PIN_CAP] == timer0MatchBOut)
        else $error("timer 0 match B not on its pin");
    a_capture_sync: assert property (timer1CaptureIn == $past(pinRawIn[PPOM_PIN_CAP], 2) || $past(rst, 2))
        else $error("capture input not synchronised");

    c_sleep_clamp: cover property (sleepClamp ##1 !sleepClamp);
    c_ref_select: cover property (adcRefSelectBit && dirReg_r[PPOM_PIN_REF]);
endmodule // ppom_port

// File: testbench/ppom_pad_model.sv
// pads and board wiring seen from the port pin override mux
module ppom_pad_model (
    input wire logic clk,
    input wire logic [7:0] padOut,
    input wire logic [7:0] padOe,
    input wire logic [7:0] padPullup,
    input wire logic [7:0] extEn,
    input wire logic [7:0] extVal,
    output logic [7:0] padIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // floating pads
    // an undriven pad without pull-up wanders every cycle, so a stale level never passes for a real one
    logic [7:0] floatPat_r = 8'h5a;
    always_ff @(posedge clk) begin
        floatPat_r <= ~floatPat_r;
    end
    // ==========================================================
    // pad level: own driver first, then board driver, then pull-up
    assign padIn = (padOe & padOut) | (~padOe & extEn & extVal) | (~padOe & ~extEn & (padPullup | floatPat_r));
endmodule // ppom_pad_model

// File: testbench/tb_port_pin_override_mux.sv
// self-checking bench for the port pin override mux
module tb_port_pin_override_mux;
    import ppom_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic [PPOM_AW-1:0] regAddr = '0;
    logic [7:0] regWdata = '0, regRdata, puEn = '0, puVal = '0, ddEn = '0, ddVal = '0, pvEn = '0, pvVal = '0;
    logic [7:0] togEn = '0, ieEn = '0, ieVal = '0, padIn, padOut, padOe, padPullup, pinRawIn, pinChangeSrc;
    logic [7:0] extEn = 8'hff, extVal = 8'h96, en;
    logic [2:0] sleepState = PPOM_ACTIVE;
    logic sdoEn = 1'b0, sdo = 1'b0, m1aEn = 1'b0, m1a = 1'b0, m1bEn = 1'b0, m1b = 1'b0, m0bEn = 1'b0, m0b = 1'b0;
    logic t0Cnt, t1Cnt, sClk, sDin, capIn;
    int n_errors = 0, comparisons = 0;
    logic [2:0] states [5] = '{PPOM_ACTIVE, PPOM_IDLE, PPOM_POWERDOWN, PPOM_POWERSAVE, PPOM_STANDBY};
    initial begin
        forever #2.5 clk = ~clk;
    end
    ppom_port i_ppom_port (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .sleepState(sleepState), .pullupOvrEn(puEn), .pullupOvrVal(puVal),
        .dirOvrEn(ddEn), .dirOvrVal(ddVal), .outvalOvrEn(pvEn), .outvalOvrVal(pvVal), .toggleOvrEn(togEn),
        .inenOvrEn(ieEn), .inenOvrVal(ieVal), .serialDataOutEn(sdoEn), .serialDataOut(sdo),
        .timer1MatchAOutEn(m1aEn), .timer1MatchAOut(m1a), .timer1MatchBOutEn(m1bEn), .timer1MatchBOut(m1b),
        .timer0MatchBOutEn(m0bEn), .timer0MatchBOut(m0b), .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .padPullup(padPullup), .pinRawIn(pinRawIn), .pinChangeSrc(pinChangeSrc), .timer0CountIn(t0Cnt),
        .timer1CountIn(t1Cnt), .serialIfClock(sClk), .serialDataIn(sDin), .timer1CaptureIn(capIn));
    ppom_pad_model i_ppom_pad_model (.clk(clk), .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
        .extEn(extEn), .extVal(extVal), .padIn(padIn));
    // ==========================================================
    // compare, bus and closing tasks
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so they are sampled there
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        cmp(regRdata, exp);
    endtask
    // combinational paths: let one edge's assignments land, then look
    task automatic settle();
        @(posedge clk);
        #1;
    endtask
    task automatic end_sim();
        $display("errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // watchdog: the tests need under a hundred cycles
    initial begin
        #20000;
        n_errors++;
        end_sim();
    end
    // ==========================================================
    // test sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(PPOM_OFS_DIR, 8'h00);
        rd(PPOM_OFS_OUT, 8'h00);
        rd(PPOM_OFS_CTRL, 8'h00);
        rd(3'h5, 8'h00);
        cmp(padOe, 8'h00);
        cmp(pinRawIn, 8'h96);
        rd(PPOM_OFS_IN, 8'h96);
        cmp(pinChangeSrc, 8'h96);
        // timer 1 count and serial clock share pin 4, timer 0 count sits on pin 3
        cmp({3'h0, capIn, sDin, sClk, t1Cnt, t0Cnt},
            {3'h0, extVal[7], extVal[6], extVal[4], extVal[4], extVal[3]});
        // plain pin configuration, then pull-up disable and pull-up override
        wr(PPOM_OFS_OUT, 8'hff);
        wr(PPOM_OFS_DIR, 8'h0f);
        extEn <= 8'hf0;
        settle();
        cmp(padOe, 8'h0f);
        cmp(padPullup, 8'hf0);
        cmp(padOut & padOe, 8'h0f);
        wr(PPOM_OFS_CTRL, 8'h01);
        settle();
        cmp(padPullup, 8'h00);
        @(posedge clk);
        puEn <= 8'hff;
        puVal <= 8'h5a;
        settle();
        cmp(padPullup, 8'h5a);
        @(posedge clk);
        puEn <= 8'h00;
        wr(PPOM_OFS_CTRL, 8'h00);
        // driver and value overrides, then fixed peripheral outputs
        ddEn <= 8'hff;
        ddVal <= 8'h3c;
        settle();
        cmp(padOe, 8'h3c);
        @(posedge clk);
        pvEn <= 8'hff;
        pvVal <= 8'ha5;
        settle();
        cmp(padOut & 8'h3c, 8'h24);
        @(posedge clk);
        // timer 1 match B asks for one on pin 5 too, so serial data must win there
        {ddVal, pvEn, sdoEn, sdo, m1bEn, m1b, m1aEn, m1a, m0bEn, m0b} <= {8'hff, 8'h00, 8'b1011_1010};
        settle();
        cmp(padOut, 8'h1f);
        @(posedge clk);
        {ddEn, sdoEn, m1bEn, m1aEn, m0bEn} <= '0;
        // toggling by input-bit write and by toggle override
        wr(PPOM_OFS_IN, 8'h0f);
        rd(PPOM_OFS_OUT, 8'hf0);
        @(posedge clk);
        togEn <= 8'h01;
        @(posedge clk);
        togEn <= 8'h00;
        rd(PPOM_OFS_OUT, 8'hf1);
        // reference select takes pin zero away
        wr(PPOM_OFS_DIR, 8'h01);
        wr(PPOM_OFS_CTRL, 8'h02);
        settle();
        cmp(padOe & 8'h01, 8'h00);
        wr(PPOM_OFS_DIR, 8'h00);
        settle();
        cmp(padPullup & 8'h01, 8'h00);
        wr(PPOM_OFS_CTRL, 8'h00);
        settle();
        cmp(padPullup & 8'h01, 8'h01);
        // digital input enable across every sleep state, half the pins overridden
        @(posedge clk);
        extEn <= 8'hff;
        extVal <= 8'hc3;
        ieEn <= 8'h0f;
        ieVal <= 8'h05;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            sleepState <= states[i];
            settle();
            en = (ieEn & ieVal) | (~ieEn & ((i >= 2) ? 8'h00 : 8'hff));
            cmp(pinRawIn, extVal & en);
        end
        end_sim();
    end
endmodule // tb_port_pin_override_mux
